// ===== shared/core_irq_map.vh
// Register offsets, field positions, vectors and mode codes of the interrupt controller
`ifndef CORE_IRQ_MAP_VH
`define CORE_IRQ_MAP_VH

// Bus and program counter widths
`define IRQ_ADDR_W      8
`define IRQ_DATA_W      8
`define IRQ_PC_W        12

// Register offsets
`define IRQ_OPTION_ADDR 8'hC8
`define IRQ_STATUS_ADDR 8'hCA
`define IRQ_EVENT_ADDR  8'hCB

// Option register layout and reset value
`define IRQ_OPTION_RST  8'h00
`define IRQ_OPTION_MASK 8'h70
`define IRQ_LES_BIT     6
`define IRQ_ESB_BIT     5
`define IRQ_GEN_BIT     4

// Status register layout
`define IRQ_ST_NMI_BIT  0
`define IRQ_ST_SRC1_BIT 1
`define IRQ_ST_SRC2_BIT 2
`define IRQ_ST_MODE_LSB 3
`define IRQ_ST_SP_LSB   5

// Fixed vector words in program space
`define IRQ_VEC_SRC0    12'hFFC
`define IRQ_VEC_SRC1    12'hFF6
`define IRQ_VEC_SRC2    12'hFF4
`define IRQ_VEC_SRC3    12'hFF2
`define IRQ_VEC_SRC4    12'hFF0

// Core operating modes, also the flag set index
`define IRQ_MODE_NORMAL 2'h0
`define IRQ_MODE_IRQ    2'h1
`define IRQ_MODE_NMI    2'h2

// Default sizes
`define IRQ_STACK_DEPTH 6
`define IRQ_EVT_W       4

`endif

// ===== hdl/pin_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter       WIDTH   = 1,
  parameter [0:0] IDLE    = 1'b1
) (
  input  wire             core_clk_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] level_o
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  reg [WIDTH-1:0] level_q;

  // First stage feeds only the second; the filter looks at stages two and three
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s1_q    <= {WIDTH{IDLE}};
      s2_q    <= {WIDTH{IDLE}};
      s3_q    <= {WIDTH{IDLE}};
      level_q <= {WIDTH{IDLE}};
    end else begin
      s1_q    <= pin_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= (s2_q & s3_q) | (level_q & (s2_q ^ s3_q)) | (s2_q & s3_q);
    end
  end

  assign level_o = level_q;

endmodule // pin_sync

`default_nettype wire

// ===== hdl/core_interrupt_controller.v
// Interrupt request, priority, entry and return logic for an 8-bit core
// Summary of operation
// - Four maskable sources plus top-ranked non-maskable source
// - Each source has its fixed vector word
// - Accepted request loads PC with its vector
// - Events OR onto sources; per-event flags readable
// - Non-maskable pre-empts all but itself; maskables never nest
// - Pending maskables served source 1 to 4
// - Global enable masks maskables and gates wake-up
// - Non-maskable request latched, cleared on entry
// - Source 1 level or falling edge by select
// - Source 2 edge, polarity bit picks direction
// - Sources 3 and 4 level only
// - Edge latch holds one request, cleared on entry
// - Level requests unstored, sampled after instruction
// - Test requests after each instruction, then enter
// - Separate carry/zero sets per mode, auto switched
// - Entry swaps flags, pushes PC, inhibits, vectors
// - Return restores flag set and pops PC
// - Disabled non-maskable still served, cannot wake
// - Option register write-only, byte wide, reset zero
`timescale 1ns/10ps
`default_nettype none
`include "core_irq_map.vh"

module core_interrupt_controller #(
  parameter EVT_W       = `IRQ_EVT_W,
  parameter STACK_DEPTH = `IRQ_STACK_DEPTH,
  parameter SP_W        = 3
) (
  input  wire                   core_clk_i,
  input  wire                   rst_n_i,
  // Register port
  input  wire [`IRQ_ADDR_W-1:0] addr_i,
  input  wire [`IRQ_DATA_W-1:0] wdata_i,
  input  wire                   wr_i,
  input  wire                   rd_i,
  output wire [`IRQ_DATA_W-1:0] rdata_o,
  // Request lines
  input  wire                   nmi_pin_n_i,
  input  wire                   src1_pin_i,
  input  wire                   src2_pin_i,
  input  wire [EVT_W-1:0]       src3_evt_i,
  input  wire [EVT_W-1:0]       src4_evt_i,
  // Core sequencer side
  input  wire                   instr_end_i,
  input  wire                   return_from_interrupt_i,
  input  wire [`IRQ_PC_W-1:0]   pc_i,
  input  wire                   sleep_i,
  input  wire                   flag_we_i,
  input  wire                   carry_i,
  input  wire                   zero_i,
  output wire                   take_o,
  output wire [`IRQ_PC_W-1:0]   vector_o,
  output wire                   ret_o,
  output wire [`IRQ_PC_W-1:0]   pc_ret_o,
  output wire [1:0]             mode_o,
  output wire                   carry_o,
  output wire                   zero_o,
  output wire                   wake_o
);

  // Synchronised pin levels
  wire        nmi_s;
  wire        src1_s;
  wire        src2_s;

  // Option register and derived controls
  reg  [`IRQ_DATA_W-1:0] irq_option_reg_q;
  wire        src1_level_select;
  wire        src2_edge_polarity;
  wire        global_irq_enable;

  // Edge history and request latches
  reg         nmi_prev_q;
  reg         src1_prev_q;
  reg         src2_prev_q;
  reg         nmi_lat_q;
  reg         src1_lat_q;
  reg         src2_lat_q;
  wire        nmi_edge;
  wire        src1_edge;
  wire        src2_edge;

  // Request arbitration
  wire [4:1]  mask_req;
  wire        stack_full;
  wire        can_nmi;
  wire        can_mask;
  wire        take_nmi;
  wire        take_mask;
  reg  [2:0]  sel_src;
  reg  [`IRQ_PC_W-1:0] sel_vec;

  // Mode, stack and outputs
  reg  [1:0]  mode_q;
  reg  [SP_W-1:0] sp_q;
  reg  [`IRQ_PC_W-1:0] stk_pc [0:STACK_DEPTH-1];
  reg  [1:0]  stk_mode [0:STACK_DEPTH-1];
  wire        do_ret;
  wire [SP_W-1:0] sp_top;
  reg         take_q;
  reg  [`IRQ_PC_W-1:0] vector_q;
  reg         ret_q;
  reg  [`IRQ_PC_W-1:0] pc_ret_q;
  reg  [`IRQ_DATA_W-1:0] rdata_q;
  wire [2:0]  carry_set;
  wire [2:0]  zero_set;

  // NMI idles high and is taken on its falling edge
  pin_sync #(
    .WIDTH (3),
    .IDLE  (1'b1)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .pin_i      ({nmi_pin_n_i, src2_pin_i, src1_pin_i}),
    .level_o    ({nmi_s, src2_s, src1_s})
  );

  assign src1_level_select  = irq_option_reg_q[`IRQ_LES_BIT];
  assign src2_edge_polarity = irq_option_reg_q[`IRQ_ESB_BIT];
  assign global_irq_enable  = irq_option_reg_q[`IRQ_GEN_BIT];

  // Option register: whole-byte writes only, no read path, cleared on reset
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_option_reg_q <= `IRQ_OPTION_RST;
    end else if (wr_i && (addr_i == `IRQ_OPTION_ADDR)) begin
      irq_option_reg_q <= wdata_i & `IRQ_OPTION_MASK;
    end
  end

  // Edge detection on the filtered pin levels
  assign nmi_edge  = nmi_prev_q & ~nmi_s;
  assign src1_edge = src1_prev_q & ~src1_s;
  assign src2_edge = src2_edge_polarity ? (~src2_prev_q & src2_s)
                                        : (src2_prev_q & ~src2_s);

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      nmi_prev_q  <= 1'b1;
      src1_prev_q <= 1'b1;
      src2_prev_q <= 1'b1;
    end else begin
      nmi_prev_q  <= nmi_s;
      src1_prev_q <= src1_s;
      src2_prev_q <= src2_s;
    end
  end

  // Request latches: one stored request each, a new edge wins over the entry clear
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      nmi_lat_q  <= 1'b0;
      src1_lat_q <= 1'b0;
      src2_lat_q <= 1'b0;
    end else begin
      if (nmi_edge)
        nmi_lat_q <= 1'b1;
      else if (take_nmi)
        nmi_lat_q <= 1'b0;
      if (src1_edge && !src1_level_select)
        src1_lat_q <= 1'b1;
      else if (take_mask && (sel_src == 3'h1))
        src1_lat_q <= 1'b0;
      if (src2_edge)
        src2_lat_q <= 1'b1;
      else if (take_mask && (sel_src == 3'h2))
        src2_lat_q <= 1'b0;
    end
  end

  // Level sources are looked at only now, nothing is stored for them
  assign mask_req[1] = src1_level_select ? ~src1_s : src1_lat_q;
  assign mask_req[2] = src2_lat_q;
  assign mask_req[3] = |src3_evt_i;
  assign mask_req[4] = |src4_evt_i;

  // A full stack refuses entry rather than overwrite a return address
  assign stack_full = (sp_q == STACK_DEPTH[SP_W-1:0]);

  // Non-maskable runs whatever the enable and mode, except inside itself
  assign can_nmi  = nmi_lat_q && (mode_q != `IRQ_MODE_NMI) && !stack_full;
  // Maskables only from normal mode, so they never nest and wait out an NMI
  assign can_mask = global_irq_enable && (|mask_req) &&
                    (mode_q == `IRQ_MODE_NORMAL) && !stack_full;

  // Requests are tested only at an instruction boundary; a return goes first
  assign take_nmi  = instr_end_i && !return_from_interrupt_i && can_nmi;
  assign take_mask = instr_end_i && !return_from_interrupt_i && !can_nmi &&
                     can_mask;

  // Fixed priority pick and vector lookup
  always @* begin
    sel_src = 3'h0;
    sel_vec = `IRQ_VEC_SRC0;
    if (!can_nmi) begin
      if (mask_req[1]) begin
        sel_src = 3'h1;
        sel_vec = `IRQ_VEC_SRC1;
      end else if (mask_req[2]) begin
        sel_src = 3'h2;
        sel_vec = `IRQ_VEC_SRC2;
      end else if (mask_req[3]) begin
        sel_src = 3'h3;
        sel_vec = `IRQ_VEC_SRC3;
      end else if (mask_req[4]) begin
        sel_src = 3'h4;
        sel_vec = `IRQ_VEC_SRC4;
      end
    end
  end

  assign do_ret = return_from_interrupt_i && (sp_q != {SP_W{1'b0}});
  assign sp_top = sp_q - {{(SP_W-1){1'b0}}, 1'b1};

  // Entry and return sequencing of mode and stack pointer
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mode_q   <= `IRQ_MODE_NORMAL;
      sp_q     <= {SP_W{1'b0}};
      take_q   <= 1'b0;
      vector_q <= {`IRQ_PC_W{1'b0}};
      ret_q    <= 1'b0;
      pc_ret_q <= {`IRQ_PC_W{1'b0}};
    end else begin
      take_q <= take_nmi | take_mask;
      ret_q  <= do_ret;
      if (take_nmi || take_mask) begin
        mode_q   <= take_nmi ? `IRQ_MODE_NMI : `IRQ_MODE_IRQ;
        sp_q     <= sp_q + {{(SP_W-1){1'b0}}, 1'b1};
        vector_q <= sel_vec;
      end else if (do_ret) begin
        mode_q   <= stk_mode[sp_top];
        sp_q     <= sp_top;
        pc_ret_q <= stk_pc[sp_top];
      end
    end
  end

  // Stack storage keeps the return address and the mode left behind
  always @(posedge core_clk_i) begin
    if (take_nmi || take_mask) begin
      stk_pc[sp_q]   <= pc_i;
      stk_mode[sp_q] <= mode_q;
    end
  end

  // One carry/zero pair per mode; the active mode picks the pair
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_flag
      reg carry_q;
      reg zero_q;
      always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          carry_q <= 1'b0;
          zero_q  <= 1'b0;
        end else if (flag_we_i && (mode_q == g)) begin
          carry_q <= carry_i;
          zero_q  <= zero_i;
        end
      end
      assign carry_set[g] = carry_q;
      assign zero_set[g]  = zero_q;
    end
  endgenerate

  assign carry_o = (mode_q == `IRQ_MODE_NMI) ? carry_set[2] :
                   (mode_q == `IRQ_MODE_IRQ) ? carry_set[1] : carry_set[0];
  assign zero_o  = (mode_q == `IRQ_MODE_NMI) ? zero_set[2] :
                   (mode_q == `IRQ_MODE_IRQ) ? zero_set[1] : zero_set[0];

  // Wake needs the global enable even for NMI, unlike servicing
  assign wake_o = sleep_i && global_irq_enable &&
                  (nmi_lat_q || (|mask_req));

  // Read port: option register is write-only and reads as zero
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= {`IRQ_DATA_W{1'b0}};
    end else if (rd_i) begin
      case (addr_i)
        `IRQ_STATUS_ADDR: begin
          rdata_q <= {`IRQ_DATA_W{1'b0}};
          rdata_q[`IRQ_ST_NMI_BIT]  <= nmi_lat_q;
          rdata_q[`IRQ_ST_SRC1_BIT] <= src1_lat_q;
          rdata_q[`IRQ_ST_SRC2_BIT] <= src2_lat_q;
          rdata_q[`IRQ_ST_MODE_LSB +: 2] <= mode_q;
          rdata_q[`IRQ_ST_SP_LSB +: SP_W] <= sp_q;
        end
        `IRQ_EVENT_ADDR: begin
          rdata_q <= {src4_evt_i, src3_evt_i};
        end
        default: begin
          rdata_q <= {`IRQ_DATA_W{1'b0}};
        end
      endcase
    end else begin
      rdata_q <= {`IRQ_DATA_W{1'b0}};
    end
  end

  assign rdata_o  = rdata_q;
  assign take_o   = take_q;
  assign vector_o = vector_q;
  assign ret_o    = ret_q;
  assign pc_ret_o = pc_ret_q;
  assign mode_o   = mode_q;

endmodule // core_interrupt_controller

`default_nettype wire

// ===== bench/irq_checker.sv
// Port-level assertions for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
`include "core_irq_map.vh"
module irq_checker (
  input wire logic                   core_clk_i,
  input wire logic                   rst_n_i,
  input wire logic [`IRQ_ADDR_W-1:0] addr_i,
  input wire logic [`IRQ_DATA_W-1:0] wdata_i,
  input wire logic                   wr_i,
  input wire logic                   rd_i,
  input wire logic [`IRQ_DATA_W-1:0] rdata_o,
  input wire logic                   instr_end_i,
  input wire logic                   return_from_interrupt_i,
  input wire logic                   sleep_i,
  input wire logic                   take_o,
  input wire logic [`IRQ_PC_W-1:0]   vector_o,
  input wire logic                   ret_o,
  input wire logic [1:0]             mode_o,
  input wire logic                   wake_o
);
  logic gen_q;
  // Mirror of the enable bit, because the option register reads back as zero
  always @(posedge core_clk_i) begin
    if (!rst_n_i) gen_q <= 1'h0;
    else if (wr_i && addr_i == `IRQ_OPTION_ADDR) gen_q <= wdata_i[`IRQ_GEN_BIT];
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_ret; return_from_interrupt_i && mode_o != `IRQ_MODE_NORMAL; endsequence
  property p_take_cause; take_o |-> $past(instr_end_i && !return_from_interrupt_i); endproperty
  property p_nmi_entry; take_o && mode_o == `IRQ_MODE_NMI |->
    vector_o == `IRQ_VEC_SRC0 && $past(mode_o) != `IRQ_MODE_NMI; endproperty
  property p_mask_entry; take_o && mode_o == `IRQ_MODE_IRQ |-> $past(gen_q) &&
    $past(mode_o) == `IRQ_MODE_NORMAL &&
    vector_o inside {`IRQ_VEC_SRC1, `IRQ_VEC_SRC2, `IRQ_VEC_SRC3, `IRQ_VEC_SRC4};
  endproperty
  property p_ret; s_ret |=> ret_o; endproperty
  property p_ret_cause; ret_o |-> $past(return_from_interrupt_i); endproperty
  property p_ret_back; ret_o && $past(mode_o) == `IRQ_MODE_IRQ |-> mode_o == `IRQ_MODE_NORMAL;
  endproperty
  property p_wake; wake_o |-> sleep_i && gen_q; endproperty
  property p_rdata; $past(!rd_i || addr_i == `IRQ_OPTION_ADDR) |-> rdata_o == 8'h00; endproperty
  // Guarded by the previous reset level so a one-cycle reset is not misread
  property p_hold; !take_o && $past(rst_n_i) |-> $stable(vector_o); endproperty
  a_take_cause: assert property (p_take_cause) else $error("entry without instruction end");
  a_nmi_entry: assert property (p_nmi_entry) else $error("bad non-maskable entry");
  a_mask_entry: assert property (p_mask_entry) else $error("bad maskable entry");
  a_ret: assert property (p_ret) else $error("return not performed");
  a_ret_cause: assert property (p_ret_cause) else $error("pop without return");
  a_ret_back: assert property (p_ret_back) else $error("wrong mode after return");
  a_wake: assert property (p_wake) else $error("wake while disabled");
  a_rdata: assert property (p_rdata) else $error("read data not zero");
  a_hold: assert property (p_hold) else $error("vector changed without entry");
endmodule // irq_checker
bind core_interrupt_controller irq_checker u_chk (.core_clk_i, .rst_n_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .instr_end_i, .return_from_interrupt_i, .sleep_i, .take_o,
  .vector_o, .ret_o, .mode_o, .wake_o);
`default_nettype wire

// ===== bench/irq_core_model.sv
// Behavioural model of the core sequencer facing the controller
`timescale 1ns/10ps
`default_nettype none
module irq_core_model (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        run_i,
  input  wire logic        ret_req_i,
  input  wire logic        take_i,
  input  wire logic        ret_i,
  input  wire logic [11:0] vector_i,
  input  wire logic [11:0] pc_ret_i,
  output logic             instr_end_o,
  output logic             return_o,
  output logic      [11:0] pc_o,
  output logic      [11:0] exp_pc_o
);
  logic [1:0]  slot_q;
  logic        pend_q;
  logic [11:0] last_q;
  logic [11:0] stk_q[$];
  // One instruction per four cycles; a requested return replaces the next instruction end
  always @(posedge core_clk_i) begin
    instr_end_o <= 1'h0;
    return_o <= 1'h0;
    if (!rst_n_i) begin
      slot_q <= 2'h0;
      pend_q <= 1'h0;
      pc_o <= 12'h100;
      stk_q.delete();
    end else begin
      if (ret_req_i) pend_q <= 1'h1;
      if (run_i) slot_q <= slot_q + 2'h1;
      if (run_i && slot_q == 2'h3 && pend_q) begin
        return_o <= 1'h1;
        pend_q <= 1'h0;
      end else if (run_i && slot_q == 2'h3) begin
        instr_end_o <= 1'h1;
        // The advanced counter stands beside the end pulse, so that is what gets saved
        last_q <= pc_o + 12'h001;
        pc_o <= pc_o + 12'h001;
      end
      // Own copy of the saved counters, so pops can be judged independently
      if (take_i) begin
        stk_q.push_back(last_q);
        pc_o <= vector_i;
      end
      if (ret_i && stk_q.size() != 0) begin
        exp_pc_o <= stk_q.pop_back();
        pc_o <= pc_ret_i;
      end
    end
  end
endmodule // irq_core_model
`default_nettype wire

// ===== bench/tb.sv
// Self-checking testbench for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb;
  logic        core_clk_i, rst_n_i, wr_i, rd_i, nmi_pin_n_i, src1_pin_i, src2_pin_i;
  logic        instr_end_i, return_from_interrupt_i, sleep_i, flag_we_i, carry_i, zero_i;
  logic        take_o, ret_o, carry_o, zero_o, wake_o, run, ret_req;
  logic [7:0]  addr_i, wdata_i, rdata_o;
  logic [3:0]  src3_evt_i, src4_evt_i;
  logic [11:0] pc_i, vector_o, pc_ret_o, exp_pc;
  logic [1:0]  mode_o;
  int          fail_count, tests_run, cycles;
  core_interrupt_controller DUT (.core_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .nmi_pin_n_i, .src1_pin_i, .src2_pin_i, .src3_evt_i, .src4_evt_i, .instr_end_i,
    .return_from_interrupt_i, .pc_i, .sleep_i, .flag_we_i, .carry_i, .zero_i, .take_o,
    .vector_o, .ret_o, .pc_ret_o, .mode_o, .carry_o, .zero_o, .wake_o);
  irq_core_model core (.core_clk_i, .rst_n_i, .run_i(run), .ret_req_i(ret_req), .take_i(take_o),
    .ret_i(ret_o), .vector_i(vector_o), .pc_ret_i(pc_ret_o), .instr_end_o(instr_end_i),
    .return_o(return_from_interrupt_i), .pc_o(pc_i), .exp_pc_o(exp_pc));
  initial begin
    core_clk_i = 1'h0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // Cuts a hang short; the whole run needs a few hundred cycles
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done;
    end
  end
  task test_done;
    $display("Checks %0d, errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i); addr_i <= a; wdata_i <= d; wr_i <= 1'h1;
    @(posedge core_clk_i); wr_i <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i); addr_i <= a; rd_i <= 1'h1;
    @(posedge core_clk_i); rd_i <= 1'h0; #1;
    `CHK("rdata", e, rdata_o)
  endtask
  // Waits for an entry (r low) or a return (r high) and judges what it left behind
  task wait_for(input logic r, input logic [11:0] v, input logic [1:0] m);
    for (int k = 0; k < 300; k++) begin
      @(posedge core_clk_i); #1;
      if ((r ? ret_o : take_o) === 1'h1) break;
    end
    `CHK("event", 1'h1, r ? ret_o : take_o)
    `CHK("mode", m, mode_o)
    if (r) begin @(posedge core_clk_i); #1; `CHK("pc_ret", exp_pc, pc_ret_o) end
    else `CHK("vector", v, vector_o)
  endtask
  task ret(input logic [1:0] m);
    @(posedge core_clk_i); ret_req <= 1'h1;
    @(posedge core_clk_i); ret_req <= 1'h0;
    wait_for(1'h1, 12'h000, m);
  endtask
  task none(input int n);
    int k;
    k = 0;
    repeat (n) begin @(posedge core_clk_i); #1; if (take_o === 1'h1) k++; end
    `CHK("takes", 0, k)
  endtask
  task t_regs;
    rd(8'hC8, 8'h00); wr(8'hC8, 8'hFF); rd(8'hC8, 8'h00);
    rd(8'h55, 8'h00); rd(8'hCA, 8'h00);
    @(posedge core_clk_i); src3_evt_i <= 4'h5; src4_evt_i <= 4'hA;
    rd(8'hCB, 8'hA5);
    @(posedge core_clk_i); src3_evt_i <= 4'h0; src4_evt_i <= 4'h0;
    wr(8'hC8, 8'h00);
  endtask
  task t_prio;
    @(posedge core_clk_i); flag_we_i <= 1'h1; carry_i <= 1'h1; zero_i <= 1'h1;
    @(posedge core_clk_i); flag_we_i <= 1'h0; src1_pin_i <= 1'h0;
    src3_evt_i <= 4'h1; src4_evt_i <= 4'h8;
    wr(8'hC8, 8'h50); tick(8); run <= 1'h1;
    wait_for(1'h0, 12'hFF6, 2'h1);
    `CHK("carry", 1'h0, carry_o)
    `CHK("zero", 1'h0, zero_o)
    // Write the interrupt set with a pattern the normal set does not hold
    @(posedge core_clk_i); flag_we_i <= 1'h1; carry_i <= 1'h0;
    @(posedge core_clk_i); flag_we_i <= 1'h0; src1_pin_i <= 1'h1; #1;
    `CHK("carry", 1'h0, carry_o)
    `CHK("zero", 1'h1, zero_o)
    ret(2'h0);
    `CHK("carry", 1'h1, carry_o)
    `CHK("zero", 1'h1, zero_o)
    wait_for(1'h0, 12'hFF2, 2'h1);
    @(posedge core_clk_i); src3_evt_i <= 4'h0;
    ret(2'h0); wait_for(1'h0, 12'hFF0, 2'h1);
    @(posedge core_clk_i); src4_evt_i <= 4'h0;
  endtask
  task t_nmi;
    @(posedge core_clk_i); src3_evt_i <= 4'h2; nmi_pin_n_i <= 1'h0;
    wait_for(1'h0, 12'hFFC, 2'h2);
    rd(8'hCA, 8'h50);
    @(posedge core_clk_i); nmi_pin_n_i <= 1'h1;
    ret(2'h1); ret(2'h0);
    wait_for(1'h0, 12'hFF2, 2'h1);
    @(posedge core_clk_i); src3_evt_i <= 4'h0;
    ret(2'h0);
  endtask
  task t_edge;
    @(posedge core_clk_i); run <= 1'h0;
    wr(8'hC8, 8'h00); src2_pin_i <= 1'h0; tick(8); src2_pin_i <= 1'h1; tick(8);
    src2_pin_i <= 1'h0; src1_pin_i <= 1'h0; tick(8); src2_pin_i <= 1'h1; src1_pin_i <= 1'h1;
    tick(8); rd(8'hCA, 8'h06);
    wr(8'hC8, 8'h10); run <= 1'h1;
    wait_for(1'h0, 12'hFF6, 2'h1); rd(8'hCA, 8'h2C);
    ret(2'h0); wait_for(1'h0, 12'hFF4, 2'h1); rd(8'hCA, 8'h28);
    ret(2'h0); none(40);
    @(posedge core_clk_i); run <= 1'h0;
    wr(8'hC8, 8'h20); src2_pin_i <= 1'h0; tick(8); rd(8'hCA, 8'h00);
    @(posedge core_clk_i); src2_pin_i <= 1'h1; tick(8); rd(8'hCA, 8'h04);
  endtask
  task t_mask;
    @(posedge core_clk_i); src3_evt_i <= 4'h4; sleep_i <= 1'h1; run <= 1'h1;
    none(40);
    `CHK("wake", 1'h0, wake_o)
    @(posedge core_clk_i); run <= 1'h0; nmi_pin_n_i <= 1'h0; tick(8); #1;
    `CHK("wake", 1'h0, wake_o)
    rd(8'hCA, 8'h05);
    @(posedge core_clk_i); run <= 1'h1; wait_for(1'h0, 12'hFFC, 2'h2);
    @(posedge core_clk_i); nmi_pin_n_i <= 1'h1; ret(2'h0);
    @(posedge core_clk_i); run <= 1'h0; wr(8'hC8, 8'h30); tick(1); #1;
    `CHK("wake", 1'h1, wake_o)
    @(posedge core_clk_i); sleep_i <= 1'h0; src3_evt_i <= 4'h0; tick(2); run <= 1'h1;
    wait_for(1'h0, 12'hFF4, 2'h1);
    ret(2'h0); none(40);
  endtask
  initial begin
    {wr_i, rd_i, sleep_i, flag_we_i, carry_i, zero_i, run, ret_req, rst_n_i} = 9'h000;
    {nmi_pin_n_i, src1_pin_i, src2_pin_i} = 3'h7;
    {addr_i, wdata_i, src3_evt_i, src4_evt_i} = 24'h000000;
    {fail_count, tests_run, cycles} = 0;
    tick(10); rst_n_i <= 1'h1; tick(5);
    t_regs;
    t_prio;
    t_nmi;
    t_edge;
    t_mask;
    test_done;
  end
endmodule // tb
`default_nettype wire
